// File: test/tb.sv
// Self-checking bench for the slave-mode controller
`timescale 1ns/10ps
module tb import tsm_pkg::*; ();
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, er;
  logic        pready, pslverr, dts = 0, run = 0, encSel = 0, eRun = 0, eRev = 0, encPin;
  logic        cntTick, cntDown, cntRestart, cntStart, trgiLevel, trgiRise, mss, etc;
  logic [1:0]  quad;
  logic [15:0] sv = 0;
  logic [31:0] nTick = 0, nRst = 0, nStart = 0, nMss = 0, nCond = 0;
  logic        clr = 0;
  int          n_errors = 0, cmp_count = 0;
  always #50 clk = ~clk;
  always @(posedge clk) dts <= ~dts;
  always @(posedge clk) if (clr) begin
    {nTick, nRst, nStart, nMss, nCond} <= '0;
  end else begin
    nTick <= nTick + 32'(cntTick);
    nRst <= nRst + 32'(cntRestart);
    nStart <= nStart + 32'(cntStart);
    nMss <= nMss + 32'(mss);
    nCond <= nCond + 32'(etc);
  end
  tsm_enc_model i_tsm_enc_model (.clk(clk), .run(eRun), .rev(eRev), .pin(encPin), .quad(quad));
  tsm_slave_ctrl #(.ADDR_W(8)) i_tsm_slave_ctrl (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extTrigIn(encSel ? encPin : sv[7]),
    .deadTimeSampleEn(dts), .internalTrigger(sv[3:0]), .ch0EdgeFlag(sv[4]),
    .chFilteredIn({sv[9], sv[8], encSel ? quad : sv[6:5]}), .multiChFilteredIn(sv[13:10]),
    .counterRunBit(run), .cntTick(cntTick), .cntDown(cntDown), .cntRestart(cntRestart),
    .cntStart(cntStart), .trgiLevel(trgiLevel), .trgiRise(trgiRise),
    .masterSlaveStart(mss), .extTrigConditioned(etc));
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    cmp_count++;
    if (!(g >= lo && g <= hi)) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask : rng
  // Whole-word transfers only; the watchdog bounds the wait for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = 32'(pslverr);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wcf(input logic [3:0] s, input logic [2:0] m, input logic [31:0] x);
    apb(1, TSM_SMCFG_OFS, x | (32'(s[3]) << TSM_TRIGGER_SOURCE_SELECT_HI_BIT) | (32'(s[2:0]) << TSM_TRIGGER_SOURCE_SELECT_LSB)
        | 32'(m));
  endtask : wcf
  task clrc;
    clr <= 1;
    @(posedge clk) clr <= 0;
  endtask : clrc
  task pul(input int b, input int k, input int w);
    repeat (k) begin
      sv[b] <= 1;
      repeat (w) @(posedge clk);
      sv[b] <= 0;
      repeat (w) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : pul
  task t_regs;
    apb(0, TSM_SMCFG_OFS, 0);
    chk(rd, TSM_SMCFG_RST);
    apb(1, TSM_SMCFG_OFS, 32'hFFFFFFFF);
    apb(0, TSM_SMCFG_OFS, 0);
    chk(rd, TSM_SMCFG_MASK);
    apb(0, 8'h20, 0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    apb(1, TSM_STATUS_OFS, 32'hFFFFFFFF);
    chk(er, 32'h0);
    wcf(4'hF, TSM_SM_OFF, 0);
    wcf(4'h0, TSM_SM_OFF, 0);
  endtask : t_regs
  task t_sel;
    for (int c = 0; c < 16; c++) begin
      sv <= 16'h1 << c;
      wcf(c[3:0], TSM_SM_OFF, 0);
      repeat (8) @(posedge clk);
      chk(32'(trgiLevel), 32'(c < 14));
      apb(0, TSM_STATUS_OFS, 0);
      chk(rd, (32'(c < 14) << TSM_ST_TRIGGER_INPUT_BIT) | (32'(c == 7) << TSM_ST_ETR_BIT));
    end
    sv <= 0;
    wcf(0, TSM_SM_OFF, 0);
  endtask : t_sel
  task t_modes;
    run <= 1;
    clrc;
    repeat (20) @(posedge clk);
    rng(nTick, 19, 21);
    wcf(0, TSM_SM_PAUSE, 0);
    clrc;
    repeat (20) @(posedge clk);
    chk(nTick, 0);
    sv[0] <= 1;
    clrc;
    repeat (20) @(posedge clk);
    rng(nTick, 15, 21);
    sv[0] <= 0;
    wcf(0, TSM_SM_RESTART, 32'h1 << TSM_MSM_BIT);
    clrc;
    pul(0, 1, 4);
    chk(nRst, 1);
    chk(nMss, 1);
    wcf(0, TSM_SM_EVENT, 0);
    clrc;
    pul(0, 1, 4);
    chk(nStart, 1);
    wcf(0, TSM_SM_EXTCLK0, 0);
    clrc;
    pul(0, 5, 3);
    chk(nTick, 5);
    wcf(0, TSM_SM_OFF, 0);
  endtask : t_modes
  task t_etr;
    int fc[4] = '{1, 3, 4, 15};
    int sh[4] = '{1, 5, 12, 200};
    int lg[4] = '{6, 14, 40, 700};
    for (int k = 0; k < 4; k++) begin
      wcf(0, TSM_SM_OFF, (32'h1 << TSM_ECM1_BIT) | (32'(k) << TSM_PSC_LSB));
      clrc;
      pul(7, 16, 3);
      rng(nTick, (16 >> k) - 1, (16 >> k) + 1);
    end
    wcf(0, TSM_SM_OFF, 32'h1 << TSM_POL_BIT);
    pul(7, 1, 4);
    chk(32'(etc), 32'h1);
    // Inverted idle level must drain out before the filter counts start
    wcf(0, TSM_SM_OFF, 0);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wcf(0, TSM_SM_OFF, 32'(fc[i]) << TSM_FLT_LSB);
      clrc;
      pul(7, 1, sh[i]);
      chk(nCond, 0);
      clrc;
      pul(7, 1, lg[i]);
      rng(nCond, 1, 2 * lg[i]);
    end
    // Source 7 with external clock modes 0 and 1 both selected here
    wcf(7, TSM_SM_EXTCLK0, 32'h1 << TSM_ECM1_BIT);
    clrc;
    pul(7, 4, 4);
    rng(nTick, 3, 5);
    wcf(7, TSM_SM_OFF, 0);
    wcf(0, TSM_SM_OFF, 0);
  endtask : t_etr
  task t_quad;
    logic [31:0] ex[3] = '{4, 4, 8};
    encSel <= 1;
    for (int m = 1; m < 4; m++) begin
      wcf(0, m[2:0], 0);
      for (int r = 0; r < 2; r++) begin
        eRev <= r[0];
        eRun <= 1;
        clrc;
        repeat (31) @(posedge clk);
        eRun <= 0;
        repeat (6) @(posedge clk);
        rng(nTick, ex[m-1] - 1, ex[m-1] + 1);
        // Forward rotation counts up in every quadrature mode
        chk(32'(cntDown), 32'(r[0]));
      end
    end
    wcf(0, TSM_SM_OFF, 0);
    encSel <= 0;
  endtask : t_quad
  task end_sim;
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    #3000000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    t_regs;
    t_sel;
    t_modes;
    t_etr;
    t_quad;
    end_sim;
  end
endmodule : tb

// File: test/tsm_enc_model.sv
// Encoder and trigger-pin source on the far side
`timescale 1ns/10ps
module tsm_enc_model (
  // Clock
  input wire logic  clk,
  // Control
  input wire logic  run,
  input wire logic  rev,
  // Pins
  output logic       pin,
  output logic [1:0] quad
);
  logic [1:0] ph  = 2'h0;
  logic [1:0] div = 2'h0;
  always @(posedge clk) if (run) div <= div + 2'h1;
  // One step in four cycles keeps edges under a quarter clock
  always @(posedge clk) if (run && div == 2'h3) ph <= rev ? ph - 2'h1 : ph + 2'h1;
  assign quad = {ph[1], ph[1] ^ ph[0]};
  assign pin  = ph[0];
endmodule : tsm_enc_model

// File: test/tsm_slave_ctrl_sva.sv
// Port-level checks for the slave-mode controller
`timescale 1ns/10ps
module tsm_slave_ctrl_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Counter control
  input wire logic        counterRunBit,
  input wire logic        cntTick,
  input wire logic        cntStart,
  input wire logic        trgiLevel,
  input wire logic        trgiRise,
  input wire logic        masterSlaveStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_RDY: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready stray");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply");
  AST_RISE: assert property (trgiRise |-> trgiLevel ##1 !trgiRise)
    else $error("rise pulse");
  AST_LVL: assert property ($rose(trgiLevel) |-> trgiRise)
    else $error("rise missed");
  AST_MSS: assert property (masterSlaveStart |-> trgiRise || $past(trgiRise))
    else $error("sync start");
  AST_TICK: assert property (cntTick |-> $past(counterRunBit))
    else $error("tick idle");
  AST_START: assert property (cntStart |-> trgiRise || $past(trgiRise) ##1 !cntStart)
    else $error("start pulse");
endmodule : tsm_slave_ctrl_sva

bind tsm_slave_ctrl tsm_slave_ctrl_sva i_sva (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .counterRunBit(counterRunBit), .cntTick(cntTick), .cntStart(cntStart),
  .trgiLevel(trgiLevel), .trgiRise(trgiRise), .masterSlaveStart(masterSlaveStart));

// File: verilog/tsm_etr_filter.sv
// Digital glitch filter for the external trigger path
`timescale 1ns/10ps
module tsm_etr_filter
  import tsm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Sampling control
  input  wire logic       dtsEn,
  input  wire logic [3:0] fltCtrl,
  // Data
  input  wire logic       din,
  output logic            dout
);

  logic [4:0] divCnt_q;
  logic [3:0] sameCnt_q;
  logic [5:0] divSel;
  logic [3:0] needCnt;
  logic       sampleEn;

  // Returns {divisor of the dead-time rate, samples needed}
  function automatic logic [9:0] flt_decode(input logic [3:0] code);
    case (code)
      4'h1:    flt_decode = {6'h01, 4'h2};
      4'h2:    flt_decode = {6'h01, 4'h4};
      4'h3:    flt_decode = {6'h01, 4'h8};
      4'h4:    flt_decode = {6'h02, 4'h6};
      4'h5:    flt_decode = {6'h02, 4'h8};
      4'h6:    flt_decode = {6'h04, 4'h6};
      4'h7:    flt_decode = {6'h04, 4'h8};
      4'h8:    flt_decode = {6'h08, 4'h6};
      4'h9:    flt_decode = {6'h08, 4'h8};
      4'hA:    flt_decode = {6'h10, 4'h5};
      4'hB:    flt_decode = {6'h10, 4'h6};
      4'hC:    flt_decode = {6'h10, 4'h8};
      4'hD:    flt_decode = {6'h20, 4'h5};
      4'hE:    flt_decode = {6'h20, 4'h6};
      4'hF:    flt_decode = {6'h20, 4'h8};
      default: flt_decode = {6'h01, 4'h1};
    endcase
  endfunction : flt_decode

  assign {divSel, needCnt} = flt_decode(fltCtrl);

  // Fast codes sample every kernel clock, slow ones every N dead-time ticks [RULE_08]
  assign sampleEn = (fltCtrl <= TSM_FLT_FAST_MAX) ? 1'b1 :
                    (dtsEn && ({1'b0, divCnt_q} == divSel - 6'h01));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      divCnt_q <= 5'h00;
    end else if (fltCtrl <= TSM_FLT_FAST_MAX) begin
      divCnt_q <= 5'h00;
    end else if (dtsEn) begin
      divCnt_q <= sampleEn ? 5'h00 : divCnt_q + 5'h01;
    end
  end

  // New level accepted only after enough consecutive equal samples [RULE_07]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sameCnt_q <= 4'h0;
      dout      <= 1'b0;
    end else if (fltCtrl == 4'h0) begin
      sameCnt_q <= 4'h0;
      dout      <= din;
    end else if (sampleEn) begin
      if (din == dout) begin
        sameCnt_q <= 4'h0;
      end else if (sameCnt_q + 4'h1 >= needCnt) begin
        sameCnt_q <= 4'h0;
        dout      <= din;
      end else begin
        sameCnt_q <= sameCnt_q + 4'h1;
      end
    end
  end

endmodule : tsm_etr_filter

// File: verilog/tsm_pkg.sv
// Shared constants and types for the timer slave-mode and trigger control block
package tsm_pkg;

  // Register map (byte addresses)
  localparam logic [7:0]  TSM_SMCFG_OFS   = 8'h08;
  localparam logic [7:0]  TSM_STATUS_OFS  = 8'h10;
  localparam logic [31:0] TSM_SMCFG_RST   = 32'h0000_0000;
  localparam logic [31:0] TSM_SMCFG_MASK  = 32'h8000_FFF7;

  // Field positions in slave_mode_config
  localparam int TSM_TRIGGER_SOURCE_SELECT_HI_BIT  = 31;
  localparam int TSM_POL_BIT      = 15;
  localparam int TSM_ECM1_BIT     = 14;
  localparam int TSM_PSC_LSB      = 12;
  localparam int TSM_FLT_LSB      = 8;
  localparam int TSM_MSM_BIT      = 7;
  localparam int TSM_TRIGGER_SOURCE_SELECT_LSB     = 4;
  localparam int TSM_SMC_LSB      = 0;

  // Field positions in the status word
  localparam int TSM_ST_TRIGGER_INPUT_BIT  = 0;
  localparam int TSM_ST_ETR_BIT   = 1;
  localparam int TSM_ST_DOWN_BIT  = 2;

  // Trigger source codes
  localparam logic [3:0] TSM_TRG_CH0EDGE = 4'h4;
  localparam logic [3:0] TSM_TRG_CH0F    = 4'h5;
  localparam logic [3:0] TSM_TRG_CH1F    = 4'h6;
  localparam logic [3:0] TSM_TRG_ETR     = 4'h7;
  localparam logic [3:0] TSM_TRG_CH2F    = 4'h8;
  localparam logic [3:0] TSM_TRG_CH3F    = 4'h9;

  // Filter codes at or below this value sample at the kernel clock
  localparam logic [3:0] TSM_FLT_FAST_MAX = 4'h3;

  typedef enum logic [2:0] {
    TSM_SM_OFF     = 3'b000,
    TSM_SM_QUAD0   = 3'b001,
    TSM_SM_QUAD1   = 3'b010,
    TSM_SM_QUAD2   = 3'b011,
    TSM_SM_RESTART = 3'b100,
    TSM_SM_PAUSE   = 3'b101,
    TSM_SM_EVENT   = 3'b110,
    TSM_SM_EXTCLK0 = 3'b111
  } tsm_mode_e;

endpackage : tsm_pkg

// File: verilog/tsm_slave_ctrl.sv
// Timer slave-mode controller: trigger conditioning, selection and counter control
// How it works
// (RULE_01) Polarity bit inverts the external trigger
// (RULE_02) Clock mode 1 counts conditioned trigger edges
// (RULE_03) Software avoids source 7 with mode 1
// (RULE_04) Both clock modes use conditioned trigger
// (RULE_05) Prescaler divides by 1, 2, 4, 8
// (RULE_06) Software keeps trigger under quarter clock
// (RULE_07) Filter needs consecutive equal samples
// (RULE_08) Filter code sets count and sample rate
// (RULE_09) Master-slave bit links timer starts
// (RULE_10) Four-bit source field split 31, 6:4
// (RULE_11) Source code picks trigger input signal
// (RULE_12) Software keeps source fixed in slave mode
// (RULE_13) Mode off: kernel clock while running
// (RULE_14) Modes 1-3 decode quadrature inputs
// (RULE_15) Restart mode reinitialises on trigger rise
// (RULE_16) Pause mode gates clock by trigger level
// (RULE_17) Event mode starts counter on rise
// (RULE_18) Clock mode 0 counts trigger rises
// (RULE_19) Software uses whole word accesses only
// (RULE_20) Polarity, then prescaler, then filter
// (RULE_21) Edges sampled on kernel clock as pulses
`timescale 1ns/10ps
module tsm_slave_ctrl
  import tsm_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // External trigger pin and dead-time sample enable
  input  wire logic              extTrigIn,
  input  wire logic              deadTimeSampleEn,
  // Trigger sources and counter run bit on the kernel clock
  input  wire logic [3:0]        internalTrigger,
  input  wire logic              ch0EdgeFlag,
  input  wire logic [3:0]        chFilteredIn,
  input  wire logic [3:0]        multiChFilteredIn,
  input  wire logic              counterRunBit,
  // Counter control
  output logic                   cntTick,
  output logic                   cntDown,
  output logic                   cntRestart,
  output logic                   cntStart,
  output logic                   trgiLevel,
  output logic                   trgiRise,
  output logic                   masterSlaveStart,
  output logic                   extTrigConditioned
);

  logic [31:0] smcfg_q;
  logic        pinMeta_q;
  logic        pinSync_q;
  logic [2:0]  pscCnt_q;
  logic        polPrev_q;
  logic        pscOut;
  logic        polIn;
  logic        etrFilt;
  logic        etrPrev_q;
  logic        etrRise;
  logic        trgiMux;
  logic        trgiPrev_q;
  logic        trgiRiseC;
  logic [1:0]  chPrev_q;
  logic        ch0Edge;
  logic        ch1Edge;
  logic        quadStep;
  logic        quadDir;
  logic        baseTick;
  logic        tickC;
  logic [3:0]  trgSel;
  logic [1:0]  pscSel;
  tsm_mode_e   mode;
  logic        accessDone;
  logic        hitCfg;
  logic        hitStat;

  assign trgSel = {smcfg_q[TSM_TRIGGER_SOURCE_SELECT_HI_BIT], smcfg_q[TSM_TRIGGER_SOURCE_SELECT_LSB+2:TSM_TRIGGER_SOURCE_SELECT_LSB]}; // [RULE_10]
  assign pscSel = smcfg_q[TSM_PSC_LSB+1:TSM_PSC_LSB];
  assign mode   = tsm_mode_e'(smcfg_q[TSM_SMC_LSB+2:TSM_SMC_LSB]);

  // APB: pready rises one cycle into the access phase; writes land on the next edge, while pready is high
  assign accessDone = psel && penable && pready;
  assign hitCfg     = (paddr == TSM_SMCFG_OFS);
  assign hitStat    = (paddr == TSM_STATUS_OFS);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !(hitCfg || hitStat);
      if (!pwrite && hitCfg) begin
        prdata <= smcfg_q;
      end else if (!pwrite && hitStat) begin
        prdata <= 32'h0000_0000;
        prdata[TSM_ST_TRIGGER_INPUT_BIT] <= trgiLevel;
        prdata[TSM_ST_ETR_BIT]  <= extTrigConditioned;
        prdata[TSM_ST_DOWN_BIT] <= cntDown;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Byte lanes are not modelled; every write to slave_mode_config updates the whole word [RULE_19]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      smcfg_q <= TSM_SMCFG_RST;
    end else if (accessDone && pwrite && hitCfg) begin
      smcfg_q <= pwdata & TSM_SMCFG_MASK;
    end
  end

  // Pin synchroniser; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
    end else begin
      pinMeta_q <= extTrigIn;
      pinSync_q <= pinMeta_q;
    end
  end

  assign polIn = pinSync_q ^ smcfg_q[TSM_POL_BIT]; // [RULE_01] [RULE_20]

  // Prescaler counts active edges; its bits give the divided square wave
  always_ff @(posedge clk) begin
    if (!nrst) begin
      polPrev_q <= 1'b0;
      pscCnt_q  <= 3'h0;
    end else begin
      polPrev_q <= polIn;
      if (polIn && !polPrev_q) begin
        pscCnt_q <= pscCnt_q + 3'h1;
      end
    end
  end

  always_comb begin
    case (pscSel) // [RULE_05]
      2'h0:    pscOut = polIn;
      2'h1:    pscOut = pscCnt_q[0];
      2'h2:    pscOut = pscCnt_q[1];
      default: pscOut = pscCnt_q[2];
    endcase
  end

  // Filter sits last in the chain so it also cleans the divided wave [RULE_20]
  tsm_etr_filter u_filter (
    .clk     (clk),
    .nrst    (nrst),
    .dtsEn   (deadTimeSampleEn),
    .fltCtrl (smcfg_q[TSM_FLT_LSB+3:TSM_FLT_LSB]),
    .din     (pscOut),
    .dout    (etrFilt)
  );

  // Trigger source mux; reserved codes give a quiet low [RULE_11]
  always_comb begin
    case (trgSel)
      4'h0, 4'h1, 4'h2, 4'h3: trgiMux = internalTrigger[trgSel[1:0]];
      TSM_TRG_CH0EDGE:        trgiMux = ch0EdgeFlag;
      TSM_TRG_CH0F:           trgiMux = chFilteredIn[0];
      TSM_TRG_CH1F:           trgiMux = chFilteredIn[1];
      TSM_TRG_ETR:            trgiMux = etrFilt;
      TSM_TRG_CH2F:           trgiMux = chFilteredIn[2];
      TSM_TRG_CH3F:           trgiMux = chFilteredIn[3];
      4'hA, 4'hB, 4'hC, 4'hD: trgiMux = multiChFilteredIn[trgSel[1:0] - 2'h2];
      default:                trgiMux = 1'b0;
    endcase
  end

  // Edge history on the kernel clock [RULE_21]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      etrPrev_q  <= 1'b0;
      trgiPrev_q <= 1'b0;
      chPrev_q   <= 2'h0;
    end else begin
      etrPrev_q  <= etrFilt;
      trgiPrev_q <= trgiMux;
      chPrev_q   <= chFilteredIn[1:0];
    end
  end

  assign etrRise   = etrFilt && !etrPrev_q;
  assign trgiRiseC = trgiMux && !trgiPrev_q;
  assign ch0Edge   = chFilteredIn[0] ^ chPrev_q[0];
  assign ch1Edge   = chFilteredIn[1] ^ chPrev_q[1];

  // Quadrature: step on the counting input, direction from the other level [RULE_14]
  always_comb begin
    quadStep = 1'b0;
    quadDir  = cntDown;
    case (mode)
      TSM_SM_QUAD0: begin
        quadStep = ch0Edge;
        quadDir  = chFilteredIn[0] ^ ~chFilteredIn[1];
      end
      TSM_SM_QUAD1: begin
        quadStep = ch1Edge;
        quadDir  = chFilteredIn[1] ^ chFilteredIn[0];
      end
      TSM_SM_QUAD2: begin
        quadStep = ch0Edge || ch1Edge;
        quadDir  = ch0Edge ? (chFilteredIn[0] ^ ~chFilteredIn[1])
                           : (chFilteredIn[1] ^ chFilteredIn[0]);
      end
      default: begin
        quadStep = 1'b0;
        quadDir  = cntDown;
      end
    endcase
  end

  // Clock mode 1 wins the clock even when mode 0 is also chosen [RULE_02] [RULE_04]
  // Source 7 with mode 1 counts each etrRise once, as mode 1 alone does; software keeps them apart [RULE_03]
  assign baseTick = smcfg_q[TSM_ECM1_BIT] ? etrRise :
                    (mode == TSM_SM_EXTCLK0) ? trgiRiseC : 1'b1; // [RULE_18] [RULE_13]

  always_comb begin
    case (mode)
      TSM_SM_QUAD0, TSM_SM_QUAD1, TSM_SM_QUAD2: tickC = counterRunBit && quadStep;
      TSM_SM_PAUSE: tickC = counterRunBit && trgiMux && baseTick; // [RULE_16]
      TSM_SM_OFF:   tickC = counterRunBit && baseTick;            // [RULE_13]
      default:      tickC = counterRunBit && baseTick;
    endcase
  end

  // Counter control outputs; restart and start pulse one kernel cycle wide, cntTick can stay high [RULE_21]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cntTick    <= 1'b0;
      cntRestart <= 1'b0;
      cntStart   <= 1'b0;
    end else begin
      cntTick    <= tickC;
      cntRestart <= (mode == TSM_SM_RESTART) && trgiRiseC; // [RULE_15]
      cntStart   <= (mode == TSM_SM_EVENT) && trgiRiseC;   // [RULE_17]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cntDown <= 1'b0;
    end else if (quadStep) begin
      cntDown <= quadDir; // [RULE_14]
    end
  end

  // Source changes during a slave mode would fake an edge here [RULE_12]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trgiLevel          <= 1'b0;
      trgiRise           <= 1'b0;
      masterSlaveStart   <= 1'b0;
      extTrigConditioned <= 1'b0;
    end else begin
      trgiLevel          <= trgiMux;
      trgiRise           <= trgiRiseC;
      masterSlaveStart   <= smcfg_q[TSM_MSM_BIT] && trgiRiseC; // [RULE_09]
      extTrigConditioned <= etrFilt;
    end
  end

endmodule : tsm_slave_ctrl
